// File: design/timer_counter_channel.sv
// One timer/counter channel with its block registers and an APB slave.
// Assumes synchronous pins, the single clock pclk and an APB master.
//
// Function
// - Counter increments on each selected clock edge.
// - Rollover to zero sets overflow flag.
// - Trigger clears counter at next counted edge.
// - Block mode picks pin or chained line A.
// - Source from five internal, three external clocks.
// - Invert bit counts on opposite edge.
// - Burst passes clock only while gate high.
// - Enable/disable commands; disabled ignores start/stop.
// - B load or C compare may disable.
// - Status shows clock enabled.
// - Any trigger resets and starts if enabled.
// - B load or C compare may stop.
// - Mode bit picks capture or waveform.
// - Pin directions follow mode and event source.
// - Software trigger command issues trigger.
// - Block sync acts as software trigger.
// - C compare match may trigger.
// - External trigger sources per mode.
// - A and B capture on line A edges.
// - A/B loads alternate after each trigger.
// - Unread reload sets overrun, overwrites.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

module timer_counter_channel #(
   parameter int CNT_W = `COUNTER_BITS
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire timer_pkg::addr_type paddr,
   input wire timer_pkg::word_type pwdata,
   output timer_pkg::word_type prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`BMR_BITS-1:0] external_clock_pins,
   input wire logic [`BMR_BITS-1:0] chain_line_a,
   input wire logic io_line_a_in,
   output logic io_line_a_out,
   output logic io_line_a_oe,
   input wire logic io_line_b_in,
   output logic io_line_b_out,
   output logic io_line_b_oe,
   output logic sync_out
);
   import timer_pkg::*;

   if (CNT_W < 2 || CNT_W > 32)
   begin : g_bad_width
      $error("Counter width out of range.");
   end

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   word_type cmr, next_cmr, next_prdata, rd_word, status;
   logic [`BMR_BITS-1:0] bmr, next_bmr, xc;
   logic [`BMR_BITS:0] burst_src;
   logic [CNT_W-1:0] cv, ra, rb, rc, next_cv, next_ra, next_rb, next_rc;
   logic pend, fresh, a_ok, b_ok, ra_unread, rb_unread;
   logic next_pend, next_fresh, next_a_ok, next_b_ok;
   logic next_ra_unread, next_rb_unread;
   logic ovf_flag, ovr_flag, cmp_flag, lda_flag, ldb_flag;
   logic next_ovf_flag, next_ovr_flag, next_cmp_flag;
   logic next_lda_flag, next_ldb_flag;
   logic next_pready, next_pslverr, next_a_oe, next_b_oe;
   logic next_a_out, next_b_out, next_sync;
   run_state_type run, next_run;
   logic wave, raw_clk, gate, tick, cmp_c, trig, trig_ok;
   logic sw_trig, sync_trig, ext_hit, hit_a, hit_b, stop_ev, dis_ev;
   logic en_cmd, dis_cmd, rd_take, wr_done, wr_ccr, addr_hit;
   logic rd_sr, rd_ra, rd_rb;
   logic [2:0] src, esrc;

   sense_if sen ();

   edge_sense u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .s(sen)
   );

   clock_prescaler u_div (
      .pclk(pclk),
      .presetn(presetn),
      .d(sen)
   );

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic r, input logic f);
      edge_hit = (sel[0] & r) | (sel[1] & f);
   endfunction

   // -------------------------------------------------------------------
   // Clock selection and events
   // -------------------------------------------------------------------
   // External levels are sampled straight on pclk, so each level must
   // outlast one pclk period or an edge is missed.
   assign wave = cmr[`CMR_WAVE];
   assign xc = (bmr & chain_line_a) | (~bmr & external_clock_pins);
   assign src = cmr[`CMR_SRC_MSB:`CMR_SRC_LSB];
   assign raw_clk = (src < `CLKSRC_EXT0) ? sen.taps[src]
                  : xc[2'(src - `CLKSRC_EXT0)];
   assign sen.level = {raw_clk ^ cmr[`CMR_INVERT], xc,
                       io_line_b_in, io_line_a_in};
   assign burst_src = {xc, 1'b1};
   assign gate = burst_src[cmr[`CMR_BURST_MSB:`CMR_BURST_LSB]];
   assign tick = sen.rise[`SENSE_CLK] & gate & (run == RUN_GO);
   // The match is taken only in the cycle after the counter moved, so a
   // stopped counter resting on the compare value fires once.
   assign cmp_c = fresh & (cv == rc);

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   assign rd_take = psel & penable & ~pready & ~pwrite;
   assign wr_done = psel & penable & pready & pwrite & addr_hit;
   assign rd_sr = rd_take & (paddr == `ADDR_SR);
   assign rd_ra = rd_take & (paddr == `ADDR_RA);
   assign rd_rb = rd_take & (paddr == `ADDR_RB);
   assign wr_ccr = wr_done & (paddr == `ADDR_CCR);
   assign en_cmd = wr_ccr & pwdata[`CCR_ENABLE];
   assign dis_cmd = wr_ccr & pwdata[`CCR_DISABLE];
   assign sw_trig = wr_ccr & pwdata[`CCR_TRIGGER];
   assign sync_trig = wr_done & (paddr == `ADDR_BCR)
                    & pwdata[`BCR_SYNC];

   // -------------------------------------------------------------------
   // Triggers, loads, stop and disable
   // -------------------------------------------------------------------
   assign esrc = wave
      ? 3'(cmr[`CMR_TSEL_MSB:`CMR_TSEL_LSB]) + 3'(`SENSE_B)
      : (cmr[`CMR_TSEL_LSB] ? 3'(`SENSE_A) : 3'(`SENSE_B));
   assign ext_hit = edge_hit(cmr[`CMR_TEDGE_MSB:`CMR_TEDGE_LSB],
                             sen.rise[esrc], sen.fall[esrc])
                  & (~wave | cmr[`CMR_EVT_EN]);
   assign trig = sw_trig | sync_trig | ext_hit
               | (cmp_c & cmr[`CMR_CMP_TRIG]);
   assign trig_ok = trig & (run != RUN_OFF);
   assign hit_a = ~wave & a_ok
                & edge_hit(cmr[`CMR_LDA_MSB:`CMR_LDA_LSB],
                           sen.rise[`SENSE_A], sen.fall[`SENSE_A]);
   assign hit_b = ~wave & b_ok
                & edge_hit(cmr[`CMR_LDB_MSB:`CMR_LDB_LSB],
                           sen.rise[`SENSE_A], sen.fall[`SENSE_A]);
   assign stop_ev = cmr[`CMR_STOP] & (wave ? cmp_c : hit_b);
   assign dis_ev = dis_cmd
                 | (cmr[`CMR_DISABLE] & (wave ? cmp_c : hit_b));

   // -------------------------------------------------------------------
   // Read side
   // -------------------------------------------------------------------
   always_comb
   begin
      status = '0;
      status[`SR_OVF] = ovf_flag;
      status[`SR_OVR] = ovr_flag;
      status[`SR_CMPC] = cmp_flag;
      status[`SR_LDA] = lda_flag;
      status[`SR_LDB] = ldb_flag;
      status[`SR_CLK_ON] = (run != RUN_OFF);
      status[`SR_LINE_A] = io_line_a_in;
      status[`SR_LINE_B] = io_line_b_in;
   end

   always_comb
   begin
      rd_word = '0;
      addr_hit = 1'b1;
      case (paddr)
         `ADDR_CCR, `ADDR_BCR: rd_word = '0;
         `ADDR_CMR: rd_word = cmr;
         `ADDR_CV: rd_word = 32'(cv);
         `ADDR_RA: rd_word = 32'(ra);
         `ADDR_RB: rd_word = 32'(rb);
         `ADDR_RC: rd_word = 32'(rc);
         `ADDR_SR: rd_word = status;
         `ADDR_BMR: rd_word = 32'(bmr);
         default: addr_hit = 1'b0;
      endcase
   end

   // -------------------------------------------------------------------
   // Bus answer and configuration
   // -------------------------------------------------------------------
   // One wait state: data is taken in the first access cycle and pready
   // rises in the second, so prdata always comes from a flip-flop.
   always_comb
   begin
      next_cmr = cmr;
      next_bmr = bmr;
      next_rc = rc;
      next_pready = psel & penable & ~pready;
      next_pslverr = psel & penable & ~pready & ~addr_hit;
      next_prdata = rd_take ? rd_word : prdata;
      if (wr_done)
      begin
         case (paddr)
            `ADDR_CMR: next_cmr = pwdata & `CMR_MASK;
            `ADDR_BMR: next_bmr = pwdata[`BMR_BITS-1:0];
            `ADDR_RC: next_rc = pwdata[CNT_W-1:0];
            default: next_cmr = cmr;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Clock control
   // -------------------------------------------------------------------
   // A disable command beats an enable written in the same word.
   always_comb
   begin
      next_run = run;
      case (run)
         RUN_OFF:
            if (en_cmd & ~dis_cmd)
               next_run = RUN_HOLD;
         RUN_HOLD:
            if (dis_ev)
               next_run = RUN_OFF;
            else if (trig)
               next_run = RUN_GO;
         RUN_GO:
            if (dis_ev)
               next_run = RUN_OFF;
            else if (stop_ev & ~trig)
               next_run = RUN_HOLD;
         default:
            next_run = RUN_OFF;
      endcase
   end

   // -------------------------------------------------------------------
   // Counter, capture and flags
   // -------------------------------------------------------------------
   // Every flag lets a new event win over a read that clears it.
   always_comb
   begin
      next_cv = cv;
      next_ra = ra;
      next_rb = rb;
      next_pend = trig_ok | (pend & ~tick);
      next_fresh = tick;
      next_ovf_flag = ovf_flag & ~rd_sr;
      next_ovr_flag = (hit_a & ra_unread & ~rd_ra)
                    | (hit_b & rb_unread & ~rd_rb)
                    | (ovr_flag & ~rd_sr);
      next_cmp_flag = cmp_c | (cmp_flag & ~rd_sr);
      next_lda_flag = hit_a | (lda_flag & ~rd_sr);
      next_ldb_flag = hit_b | (ldb_flag & ~rd_sr);
      next_ra_unread = hit_a | (ra_unread & ~rd_ra);
      next_rb_unread = hit_b | (rb_unread & ~rd_rb);
      if (tick & pend)
         next_cv = '0;
      else if (tick)
      begin
         next_cv = cv + 1'b1;
         if (&cv)
            next_ovf_flag = 1'b1;
      end
      if (hit_a)
         next_ra = cv;
      else if (wr_done & wave & (paddr == `ADDR_RA))
         next_ra = pwdata[CNT_W-1:0];
      if (hit_b)
         next_rb = cv;
      else if (wr_done & wave & (paddr == `ADDR_RB))
         next_rb = pwdata[CNT_W-1:0];
      next_a_ok = a_ok;
      next_b_ok = b_ok;
      if (trig_ok)
      begin
         next_a_ok = 1'b1;
         next_b_ok = 1'b0;
      end
      else if (hit_a)
      begin
         next_a_ok = 1'b0;
         next_b_ok = 1'b1;
      end
      else if (hit_b)
      begin
         next_a_ok = 1'b1;
         next_b_ok = 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Pins
   // -------------------------------------------------------------------
   // Output shaping is minimal here: in waveform mode A toggles on a C match, B only while it is driven.
   always_comb
   begin
      next_a_oe = wave;
      next_b_oe = wave
                & (cmr[`CMR_TSEL_MSB:`CMR_TSEL_LSB] != '0);
      next_a_out = io_line_a_out ^ (wave & cmp_c);
      next_b_out = io_line_b_out ^ (next_b_oe & cmp_c);
      next_sync = sync_trig;
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmr <= `CMR_RESET;
         bmr <= '0;
         cv <= '0;
         ra <= '0;
         rb <= '0;
         rc <= '0;
         run <= RUN_OFF;
         pend <= 1'b0;
         fresh <= 1'b0;
         a_ok <= 1'b1;
         b_ok <= 1'b0;
         ra_unread <= 1'b0;
         rb_unread <= 1'b0;
         ovf_flag <= 1'b0;
         ovr_flag <= 1'b0;
         cmp_flag <= 1'b0;
         lda_flag <= 1'b0;
         ldb_flag <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         io_line_a_oe <= 1'b0;
         io_line_b_oe <= 1'b0;
         io_line_a_out <= 1'b0;
         io_line_b_out <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         cmr <= next_cmr;
         bmr <= next_bmr;
         cv <= next_cv;
         ra <= next_ra;
         rb <= next_rb;
         rc <= next_rc;
         run <= next_run;
         pend <= next_pend;
         fresh <= next_fresh;
         a_ok <= next_a_ok;
         b_ok <= next_b_ok;
         ra_unread <= next_ra_unread;
         rb_unread <= next_rb_unread;
         ovf_flag <= next_ovf_flag;
         ovr_flag <= next_ovr_flag;
         cmp_flag <= next_cmp_flag;
         lda_flag <= next_lda_flag;
         ldb_flag <= next_ldb_flag;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         io_line_a_oe <= next_a_oe;
         io_line_b_oe <= next_b_oe;
         io_line_a_out <= next_a_out;
         io_line_b_out <= next_b_out;
         sync_out <= next_sync;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_count_step: assert property (
      (tick && !pend) |=> (cv == $past(cv) + 1'b1))
      else $error("Counter did not step by one.");
   chk_overflow_set: assert property (
      (tick && !pend && (&cv)) |=> (ovf_flag && cv == '0))
      else $error("Rollover did not set the overflow flag.");
   chk_trigger_zero: assert property (
      (tick && pend) |=> (cv == '0 && pend == $past(trig_ok)))
      else $error("Pending trigger did not clear the counter.");
   chk_disabled_hold: assert property (
      (run == RUN_OFF && !en_cmd) |=> (run == RUN_OFF))
      else $error("Disabled clock restarted without enable.");
   chk_status_enabled: assert property (
      (rd_take && paddr == `ADDR_SR)
      |=> (prdata[`SR_CLK_ON] == $past(run != RUN_OFF)) && pready)
      else $error("Status does not show the enabled clock.");
   chk_trigger_start: assert property (
      (trig && run != RUN_OFF && !dis_ev) |=> (run == RUN_GO && pend))
      else $error("Trigger did not start the clock.");
   chk_sync_pulse: assert property (
      sync_trig |=> sync_out ##1 !sync_out)
      else $error("Sync output is not a single pulse.");
   chk_pin_capture: assert property (
      !wave ##1 !wave |-> (!io_line_a_oe && !io_line_b_oe))
      else $error("A line is driven in capture mode.");
   chk_load_order: assert property (
      hit_a |=> (!a_ok || $past(trig_ok)))
      else $error("Register A rearmed without B load or trigger.");
   chk_overrun_set: assert property (
      (hit_a && ra_unread && !rd_ra) |=> (ovr_flag && ra == $past(cv)))
      else $error("Unread reload did not flag overrun.");

   cov_trigger_clear: cover property (tick && pend);
   cov_a_then_b: cover property (hit_a ##[1:200] hit_b);
   cov_overrun: cover property (!ovr_flag ##1 ovr_flag);
   cov_compare_stop: cover property (stop_ev && wave);
endmodule

`default_nettype wire

// File: shared/timer_map.svh
// Register offsets, field positions and reset values of the timer channel.
// Assumes inclusion by bare name from every file that needs a constant.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define COUNTER_BITS 16
`define PRESCALE_BITS 10
`define BMR_BITS 3
`define SENSE_W 6
`define TAP_W 5

// ----------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------
`define ADDR_CCR 8'h00
`define ADDR_CMR 8'h04
`define ADDR_CV 8'h10
`define ADDR_RA 8'h14
`define ADDR_RB 8'h18
`define ADDR_RC 8'h1c
`define ADDR_SR 8'h20
`define ADDR_BCR 8'hc0
`define ADDR_BMR 8'hc4

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CCR_ENABLE 0
`define CCR_DISABLE 1
`define CCR_TRIGGER 2
`define BCR_SYNC 0
`define CMR_SRC_LSB 0
`define CMR_SRC_MSB 2
`define CMR_INVERT 3
`define CMR_BURST_LSB 4
`define CMR_BURST_MSB 5
`define CMR_STOP 6
`define CMR_DISABLE 7
`define CMR_TEDGE_LSB 8
`define CMR_TEDGE_MSB 9
`define CMR_TSEL_LSB 10
`define CMR_TSEL_MSB 11
`define CMR_EVT_EN 12
`define CMR_CMP_TRIG 14
`define CMR_WAVE 15
`define CMR_LDA_LSB 16
`define CMR_LDA_MSB 17
`define CMR_LDB_LSB 18
`define CMR_LDB_MSB 19
`define CMR_MASK 32'h000f_dfff
`define CMR_RESET 32'h0000_0000
`define SR_OVF 0
`define SR_OVR 1
`define SR_CMPC 4
`define SR_LDA 5
`define SR_LDB 6
`define SR_CLK_ON 16
`define SR_LINE_A 17
`define SR_LINE_B 18

// ----------------------------------------------------------------------
// Sensed lines and clock taps
// ----------------------------------------------------------------------
`define SENSE_A 0
`define SENSE_B 1
`define SENSE_CLK 5
`define CLKSRC_EXT0 3'h5
`define TAP1_BIT 0
`define TAP2_BIT 2
`define TAP3_BIT 4
`define TAP4_BIT 6
`define TAP5_BIT 9

`endif

// File: shared/timer_pkg.sv
// Types shared by the timer channel modules.
// Assumes nothing of its surroundings.
package timer_pkg;
   typedef logic [7:0] addr_type;
   typedef logic [31:0] word_type;
   typedef enum logic [2:0] {
      RUN_OFF = 3'h1,
      RUN_HOLD = 3'h2,
      RUN_GO = 3'h4
   } run_state_type;
endpackage

// File: shared/sense_if.sv
// Bundle of sampled lines, their edges and the prescaler clock taps.
// Assumes all members are produced and consumed in the pclk domain.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

interface sense_if;
   logic [`SENSE_W-1:0] level;
   logic [`SENSE_W-1:0] rise;
   logic [`SENSE_W-1:0] fall;
   logic [`TAP_W-1:0] taps;
   modport sensor (input level, output rise, output fall);
   modport divider (output taps);
   modport core (output level, input rise, input fall, input taps);
endinterface

`default_nettype wire

// File: design/edge_sense.sv
// Edge detector for the sampled lines of one channel.
// Assumes its inputs are already synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

module edge_sense (
   input wire logic pclk,
   input wire logic presetn,
   sense_if.sensor s
);
   logic [`SENSE_W-1:0] prev;
   logic [`SENSE_W-1:0] next_prev;

   always_comb
   begin
      next_prev = s.level;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev <= '0;
      else
         prev <= next_prev;
   end

   assign s.rise = s.level & ~prev;
   assign s.fall = ~s.level & prev;
endmodule

`default_nettype wire

// File: design/clock_prescaler.sv
// Free-running prescaler that supplies the five internal clock levels.
// Assumes a single clock pclk; taps are square waves of pclk.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

module clock_prescaler #(
   parameter int DIV_W = `PRESCALE_BITS
)(
   input wire logic pclk,
   input wire logic presetn,
   sense_if.divider d
);
   if (DIV_W <= `TAP5_BIT)
   begin : g_bad_width
      $error("Prescaler too narrow for the slowest tap.");
   end

   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] next_count;

   always_comb
   begin
      next_count = count + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= '0;
      else
         count <= next_count;
   end

   assign d.taps = {count[`TAP5_BIT], count[`TAP4_BIT], count[`TAP3_BIT],
                    count[`TAP2_BIT], count[`TAP1_BIT]};
endmodule

`default_nettype wire

// File: bench/line_model.sv
// Model of the lines beyond the channel: clock pins and lines A and B.
// Assumes one pclk; the bench moves a line through the tasks below.
`timescale 1ns/1ns
`default_nettype none

module line_model (
   input wire logic pclk,
   input wire logic a_out,
   input wire logic a_oe,
   input wire logic b_out,
   input wire logic b_oe,
   output logic [2:0] clk_pins,
   output logic line_a,
   output logic line_b
);
   logic [4:0] drv = 5'h00;

   // ------------------------------------------------------------------
   // Wire levels
   // ------------------------------------------------------------------
   // A line that the channel drives shows the channel's value.
   assign clk_pins = drv[2:0];
   assign line_a = a_oe ? a_out : drv[3];
   assign line_b = b_oe ? b_out : drv[4];

   // Each level stands three cycles, so a clock period of six cycles
   // stays slower than pclk/2.5.
   task automatic set(input int idx, input logic v);
      @(posedge pclk);
      drv[idx] <= v;
      repeat (2) @(posedge pclk);
   endtask

   task automatic pulse(input int idx, input int n);
      repeat (n)
      begin
         set(idx, 1'b1);
         set(idx, 1'b0);
      end
   endtask
endmodule

`default_nettype wire

// File: bench/timer_counter_channel_core_test.sv
// Self-checking bench for one timer channel, with a four-bit counter.
// Assumes the line model and the channel share pclk.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

module timer_counter_channel_core_test;
   import timer_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   addr_type paddr = 8'h00;
   word_type pwdata = 32'h0000_0000;
   word_type prdata, rdata;
   logic pready, pslverr, rerr;
   logic [2:0] pins;
   logic line_a, line_b, a_out, a_oe, b_out, b_oe, sync_out;
   int fail_count = 0;
   int n_compared = 0;

   // A short counter makes the rollover reachable in a few pulses.
   timer_counter_channel #(.CNT_W(4)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_clock_pins(pins),
      .chain_line_a({3{line_a}}), .io_line_a_in(line_a),
      .io_line_a_out(a_out),
      .io_line_a_oe(a_oe), .io_line_b_in(line_b), .io_line_b_out(b_out),
      .io_line_b_oe(b_oe), .sync_out(sync_out)
   );

   line_model u_lines (
      .pclk(pclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
      .b_oe(b_oe), .clk_pins(pins), .line_a(line_a), .line_b(line_b)
   );

   initial
   begin
      forever #25 pclk = ~pclk;
   end

   task automatic check(input string what, input word_type seen,
                        input word_type exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   task automatic apb(input logic w, input addr_type a, input word_type d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input addr_type a, input word_type d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string what, input addr_type a,
                      input word_type exp, input word_type m = '1);
      apb(1'b0, a, 32'h0);
      check(what, rdata & m, exp);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      rdc("mode", `ADDR_CMR, 32'h0);
      rdc("status", `ADDR_SR, 32'h0);
      rdc("hole", 8'h08, 32'h0);
      check("hole_err", {31'h0, rerr}, 32'h1);
      check("oe", {30'h0, a_oe, b_oe}, 32'h0);
   endtask

   task automatic t_count;
      wr(`ADDR_CMR, 32'h5);
      wr(`ADDR_CCR, 32'h1);
      rdc("clk_on", `ADDR_SR, 32'h1_0000, 32'h1_0000);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 5);
      rdc("count", `ADDR_CV, 32'h4);
      u_lines.pulse(0, 12);
      rdc("wrap", `ADDR_CV, 32'h0);
      rdc("ovf", `ADDR_SR, 32'h1_0001, 32'h1_0001);
   endtask

   // The pin is parked high first so the switch of sense is a falling edge, which is not counted.
   task automatic t_invert;
      u_lines.set(0, 1'b1);
      wr(`ADDR_CMR, 32'hd);
      wr(`ADDR_CCR, 32'h4);
      u_lines.set(0, 1'b0);
      u_lines.set(0, 1'b1);
      rdc("inv_rise", `ADDR_CV, 32'h0);
      u_lines.set(0, 1'b0);
      rdc("inv_fall", `ADDR_CV, 32'h1);
   endtask

   task automatic t_disable;
      wr(`ADDR_CMR, 32'h5);
      wr(`ADDR_CCR, 32'h3);
      rdc("clk_off", `ADDR_SR, 32'h0, 32'h1_0000);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 3);
      rdc("frozen", `ADDR_CV, 32'h1);
      wr(`ADDR_CCR, 32'h1);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 3);
      rdc("restart", `ADDR_CV, 32'h2);
   endtask

   task automatic t_burst;
      wr(`ADDR_CMR, 32'h25);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 2);
      rdc("gated", `ADDR_CV, 32'h2);
      u_lines.set(1, 1'b1);
      u_lines.pulse(0, 4);
      rdc("passed", `ADDR_CV, 32'h3);
      u_lines.set(1, 1'b0);
      wr(`ADDR_CMR, 32'h5);
      wr(`ADDR_BCR, 32'h1);
      @(posedge pclk);
      check("sync_out", {31'h0, sync_out}, 32'h1);
      u_lines.pulse(0, 2);
      rdc("sync", `ADDR_CV, 32'h1);
   endtask

   task automatic t_capture;
      wr(`ADDR_CMR, 32'h9_00c5);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 3);
      u_lines.set(3, 1'b1);
      u_lines.pulse(0, 2);
      u_lines.set(3, 1'b0);
      u_lines.pulse(0, 2);
      rdc("stopped", `ADDR_CV, 32'h4);
      rdc("loads", `ADDR_SR, 32'h60, 32'h1_0062);
      rdc("reg_a", `ADDR_RA, 32'h2);
      rdc("reg_b", `ADDR_RB, 32'h4);
      u_lines.set(3, 1'b1);
      u_lines.set(3, 1'b0);
      u_lines.set(3, 1'b1);
      rdc("overrun", `ADDR_SR, 32'h2, 32'h2);
      u_lines.set(3, 1'b0);
   endtask

   task automatic t_wave;
      wr(`ADDR_CMR, 32'hc405);
      repeat (2) @(posedge pclk);
      check("oe_ab", {30'h0, a_oe, b_oe}, 32'h3);
      wr(`ADDR_CMR, 32'hc005);
      repeat (2) @(posedge pclk);
      check("oe_b", {30'h0, a_oe, b_oe}, 32'h2);
      wr(`ADDR_CMR, 32'hc405);
      wr(`ADDR_RC, 32'h3);
      wr(`ADDR_CCR, 32'h1);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 6);
      rdc("c_trig", `ADDR_CV, 32'h1);
      check("outs", {30'h0, a_out, b_out}, 32'h3);
      wr(`ADDR_CMR, 32'h8445);
      u_lines.pulse(0, 4);
      rdc("c_stop", `ADDR_CV, 32'h3);
      rdc("c_held", `ADDR_SR, 32'h1_0010, 32'h1_0010);
      wr(`ADDR_CMR, 32'h8485);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(0, 5);
      rdc("c_dis", `ADDR_SR, 32'h0, 32'h1_0000);
   endtask

   // Line A is chained into every external clock input of the channel.
   task automatic t_ext;
      wr(`ADDR_CMR, 32'h505);
      wr(`ADDR_CCR, 32'h1);
      u_lines.pulse(0, 3);
      u_lines.pulse(3, 1);
      u_lines.pulse(0, 2);
      rdc("ext_trig", `ADDR_CV, 32'h1);
      wr(`ADDR_BMR, 32'h1);
      rdc("bmr", `ADDR_BMR, 32'h1);
      wr(`ADDR_CMR, 32'h5);
      wr(`ADDR_CCR, 32'h4);
      u_lines.pulse(3, 2);
      u_lines.pulse(0, 3);
      rdc("chain", `ADDR_CV, 32'h1);
   endtask

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_count();
      t_invert();
      t_disable();
      t_burst();
      t_capture();
      t_wave();
      t_ext();
      end_sim();
   end

   // The scenarios take several hundred cycles; this allows ample slack.
   initial
   begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      end_sim();
   end
endmodule

`default_nettype wire
